// ==== rtl/cfgm_defines.svh ====
`ifndef CFGM_DEFINES_SVH
`define CFGM_DEFINES_SVH

// ==========================================================================
// address window of the mirrored configuration bytes
`define CFGM_BASE_ADDR 8'hc0
`define CFGM_LAST_ADDR 8'hca
`define CFGM_NUM_BYTES 11
`define CFGM_PWR_INDEX 4'h0

// ==========================================================================
// values
`define CFGM_FACTORY_VALUE 8'h00
`define CFGM_READ_NONE 8'h00
`define CFGM_PWR_WMASK 8'h7f
`define CFGM_FULL_WMASK 8'hff

// ==========================================================================
// power management byte fields
`define CFGM_CLK_DIS_BIT 6
`define CFGM_SWMODE_HI 5
`define CFGM_SWMODE_LO 4
`define CFGM_TRICKLE_HI 3
`define CFGM_TRICKLE_LO 0

// ==========================================================================
// timing: 66 ms first refresh delay at 50 MHz
`define CFGM_FIRST_REFRESH_MS 64'h0000_0000_0000_0042
`define CFGM_CLK_HZ 64'h0000_0000_02fa_f080
`define CFGM_MS_PER_S 64'h0000_0000_0000_03e8

`endif

// ==== rtl/cfgm_nvm.sv ====
`timescale 1ns/10ps
`include "cfgm_defines.svh"
// ==========================================================================
// nonvolatile configuration store
module cfgm_nvm
	import cfgm_pkg::*;
#(
	parameter int NUM_BYTES = `CFGM_NUM_BYTES
) (
	input wire logic clk_i,
	cfgm_nvm_if.nvm nv
);
	cfgm_byte_t store_mem [NUM_BYTES];

	// no reset on purpose: contents must survive a power-on reset
	genvar g;
	for (g = 0; g < NUM_BYTES; g++) begin : g_cell
		always_ff @(posedge clk_i) begin
			if (nv.fill) begin
				store_mem[g] <= `CFGM_FACTORY_VALUE;
			end else if (nv.wr_all) begin
				store_mem[g] <= nv.mirror[g];
			end
		end
		assign nv.store[g] = store_mem[g];
	end
endmodule // cfgm_nvm

// ==== rtl/cfgm_nvm_if.sv ====
`timescale 1ns/10ps
`include "cfgm_defines.svh"
// ==========================================================================
// link between the mirror logic and the nonvolatile store
interface cfgm_nvm_if #(
	parameter int NUM_BYTES = `CFGM_NUM_BYTES
);
	logic [NUM_BYTES-1:0][7:0] mirror;
	logic [NUM_BYTES-1:0][7:0] store;
	logic wr_all;
	logic fill;

	modport ctl (output mirror, output wr_all, output fill, input store);
	modport nvm (input mirror, input wr_all, input fill, output store);
endinterface

// ==== rtl/cfgm_pkg.sv ====
package cfgm_pkg;
`include "cfgm_defines.svh"

	typedef logic [7:0] cfgm_byte_t;

	// sequencing of the power-up load
	typedef enum logic [1:0] {
		CFGM_ST_WAIT,
		CFGM_ST_LOAD,
		CFGM_ST_RUN
	} cfgm_state_e;

	// cycles of the first refresh delay, rounded down, at least one
	localparam longint unsigned CFGM_REFRESH_RAW =
		(`CFGM_FIRST_REFRESH_MS * `CFGM_CLK_HZ) / `CFGM_MS_PER_S;
	localparam int unsigned CFGM_REFRESH_CYCLES =
		(CFGM_REFRESH_RAW < 1) ? 1 : int'(CFGM_REFRESH_RAW);

endpackage

// ==== rtl/cfgm_top.sv ====
`timescale 1ns/10ps
`include "cfgm_defines.svh"
// ==========================================================================
// configuration bytes with nonvolatile store and ram mirror

// Behaviour
// - Bytes C0h..CAh live both in nonvolatile store and in a ram mirror.
// - Mirror drives the controlled functions directly; host writes act at once.
// - About 66 ms after power-up the store is copied into the mirror.
// - Factory content of the power management byte is all zeros.
// - Power management byte always readable; writes refused under write protection.
// - Byte holds switchover mode, trickle charger bits and active-low clock enable.
module cfgm_top
	import cfgm_pkg::*;
#(
	parameter int NUM_BYTES = `CFGM_NUM_BYTES,
	parameter int unsigned FIRST_REFRESH_CYCLES = CFGM_REFRESH_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic wp_active_i,
	input wire logic nvm_update_i,
	input wire logic nvm_refresh_i,
	input wire logic factory_fill_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	output logic wr_blocked_o,
	output logic first_load_done_o,
	output logic clock_output_disable_o,
	output logic [1:0] backup_switch_mode_o,
	output logic [3:0] trickle_ctrl_o
);

	// ======================================================================
	// local sizes
	localparam int IDX_W = (NUM_BYTES > 1) ? $clog2(NUM_BYTES) : 1;
	localparam int CNT_W = $clog2(FIRST_REFRESH_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FIRST_REFRESH_CYCLES - 1);

	// ======================================================================
	// address decoding, shared by the read and the write path
	function automatic logic cfgm_hit(input logic [7:0] addr);
		return (addr >= `CFGM_BASE_ADDR) && (addr <= `CFGM_LAST_ADDR);
	endfunction

	function automatic logic [IDX_W-1:0] cfgm_index(input logic [7:0] addr);
		logic [7:0] off;
		off = addr - `CFGM_BASE_ADDR;
		return off[IDX_W-1:0];
	endfunction

	// the reserved top bit of the power management byte never stores a one
	function automatic cfgm_byte_t cfgm_wmask(input int idx);
		return (idx == int'(`CFGM_PWR_INDEX)) ? `CFGM_PWR_WMASK : `CFGM_FULL_WMASK;
	endfunction

	// ======================================================================
	// state
	cfgm_state_e state_reg;
	cfgm_state_e state_next;
	logic [CNT_W-1:0] delay_cnt_reg;
	cfgm_byte_t mirror_reg [NUM_BYTES];
	cfgm_byte_t rdata_reg;
	logic rvalid_reg;
	logic blocked_reg;
	logic done_reg;
	logic load_all;
	logic wr_hit;
	logic wr_ok;
	logic [IDX_W-1:0] wr_idx;
	logic [IDX_W-1:0] rd_idx;

	cfgm_nvm_if #(.NUM_BYTES(NUM_BYTES)) nv_if ();

	// ======================================================================
	// nonvolatile store
	cfgm_nvm #(
		.NUM_BYTES(NUM_BYTES)
	) u_nvm (
		.clk_i(clk_i),
		.nv(nv_if.nvm)
	);

	// factory fill is independent of the mirror state machine
	assign nv_if.fill = factory_fill_i;

	// mirror to store copy only once the power-up load is over, so a copy
	// cannot overwrite the store with the reset value of the mirror;
	// the switchover mode is not checked, the host owns that precaution
	assign nv_if.wr_all = nvm_update_i && (state_reg == CFGM_ST_RUN);

	// ======================================================================
	// power-up sequencing
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CFGM_ST_WAIT: begin
				if (delay_cnt_reg == CNT_LAST) begin
					state_next = CFGM_ST_LOAD;
				end
			end
			CFGM_ST_LOAD: begin
				state_next = CFGM_ST_RUN;
			end
			CFGM_ST_RUN: begin
				state_next = CFGM_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_reg <= CFGM_ST_WAIT;
		end else begin
			state_reg <= state_next;
		end
	end

	// the delay counter stops once the wait is over to save toggling
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			delay_cnt_reg <= '0;
		end else if (state_reg == CFGM_ST_WAIT && delay_cnt_reg != CNT_LAST) begin
			delay_cnt_reg <= delay_cnt_reg + CNT_W'(1);
		end
	end

	// flag for software and for the functions that rely on loaded values
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			done_reg <= 1'b0;
		end else if (state_reg == CFGM_ST_LOAD) begin
			done_reg <= 1'b1;
		end
	end

	// store to mirror copy: the power-up load, or a refresh request later
	assign load_all = (state_reg == CFGM_ST_LOAD) ||
		((state_reg == CFGM_ST_RUN) && nvm_refresh_i);

	// ======================================================================
	// host write path
	assign wr_hit = reg_wr_i && cfgm_hit(reg_addr_i);
	assign wr_ok = wr_hit && !wp_active_i;
	assign wr_idx = cfgm_index(reg_addr_i);

	// one mirror cell per byte; a host write in the same cycle as a load
	// wins, since it is the newer intent of software
	genvar g;
	for (g = 0; g < NUM_BYTES; g++) begin : g_mirror
		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				mirror_reg[g] <= `CFGM_FACTORY_VALUE;
			end else if (wr_ok && wr_idx == IDX_W'(g)) begin
				mirror_reg[g] <= reg_wdata_i & cfgm_wmask(g);
			end else if (load_all) begin
				mirror_reg[g] <= nv_if.store[g] & cfgm_wmask(g);
			end
		end
		assign nv_if.mirror[g] = mirror_reg[g];
	end

	// a refused write leaves a one-cycle pulse so software can tell
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			blocked_reg <= 1'b0;
		end else begin
			blocked_reg <= wr_hit && wp_active_i;
		end
	end

	// ======================================================================
	// host read path
	assign rd_idx = cfgm_index(reg_addr_i);

	// reads ignore write protection; outside the window they return zero
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_reg <= `CFGM_READ_NONE;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= reg_rd_i;
			if (reg_rd_i) begin
				if (cfgm_hit(reg_addr_i)) begin
					rdata_reg <= mirror_reg[rd_idx];
				end else begin
					rdata_reg <= `CFGM_READ_NONE;
				end
			end
		end
	end

	// ======================================================================
	// outputs; function controls come straight from the mirror flops
	assign reg_rdata_o = rdata_reg;
	assign reg_rvalid_o = rvalid_reg;
	assign wr_blocked_o = blocked_reg;
	assign first_load_done_o = done_reg;
	assign clock_output_disable_o = mirror_reg[`CFGM_PWR_INDEX][`CFGM_CLK_DIS_BIT];
	assign backup_switch_mode_o =
		mirror_reg[`CFGM_PWR_INDEX][`CFGM_SWMODE_HI:`CFGM_SWMODE_LO];
	assign trickle_ctrl_o =
		mirror_reg[`CFGM_PWR_INDEX][`CFGM_TRICKLE_HI:`CFGM_TRICKLE_LO];

endmodule // cfgm_top

// ==== test/cfgm_host.sv ====
`timescale 1ns/10ps
// ============================================================
// host on the register bus
module cfgm_host (
	input wire logic clk_i,
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] wdata_o
);
	initial {addr_o, wr_o, rd_o, wdata_o} = 18'h0_0000;
	// one-cycle strobe; released lines flip so stale values never look valid
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		{wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
		@(negedge clk_i);
		{wr_o, rd_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
	endtask
endmodule // cfgm_host

// ==== test/cfgm_properties.sv ====
`timescale 1ns/10ps
// ============================================================
// port properties of the configuration mirror
module cfgm_properties
	import cfgm_pkg::*;
#(
	parameter int unsigned FIRST_REFRESH_CYCLES = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic wp_active_i,
	input wire logic nvm_refresh_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire logic wr_blocked_o,
	input wire logic first_load_done_o,
	input wire logic clock_output_disable_o,
	input wire logic [1:0] backup_switch_mode_o,
	input wire logic [3:0] trickle_ctrl_o
);
	logic [15:0] up_cnt;
	wire logic [7:0] pm = {1'b0, clock_output_disable_o, backup_switch_mode_o, trickle_ctrl_o};
	wire logic mapped = reg_addr_i inside {[8'hc0:8'hca]};
	// edges since release; saturates so a long run cannot wrap
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) up_cnt <= 16'h0000;
		else if (up_cnt != 16'hffff) up_cnt <= up_cnt + 16'h0001;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered");
	a_pm_readback: assert property (reg_rd_i && reg_addr_i == 8'hc0 && !reg_wr_i
		&& !nvm_refresh_i && first_load_done_o |=> reg_rdata_o == $past(pm))
		else $error("read differs from mirror");
	a_write_acts: assert property (reg_wr_i && !wp_active_i && reg_addr_i == 8'hc0
		|=> pm == ($past(reg_wdata_i) & 8'h7f)) else $error("write not applied");
	a_wp_refuses: assert property (reg_wr_i && wp_active_i && mapped
		&& first_load_done_o && !nvm_refresh_i |=> wr_blocked_o && $stable(pm))
		else $error("protected write taken");
	a_no_block: assert property (!(reg_wr_i && wp_active_i) |=> !wr_blocked_o)
		else $error("stray block pulse");
	a_unmapped_zero: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_load_time: assert property ($rose(first_load_done_o)
		|-> up_cnt == FIRST_REFRESH_CYCLES + 1) else $error("load at wrong time");
endmodule // cfgm_properties

bind cfgm_top cfgm_properties #(.FIRST_REFRESH_CYCLES(FIRST_REFRESH_CYCLES)) chk_u (.clk_i,
	.rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .wp_active_i, .nvm_refresh_i,
	.reg_rdata_o, .reg_rvalid_o, .wr_blocked_o, .first_load_done_o, .clock_output_disable_o,
	.backup_switch_mode_o, .trickle_ctrl_o);

// ==== test/testbench.sv ====
`timescale 1ns/10ps
// ============================================================
// self-checking bench for the configuration mirror
module testbench;
	import cfgm_pkg::*;
	localparam int unsigned N = 8;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wp_active_i = 1'b0;
	logic nvm_update_i = 1'b0;
	logic nvm_refresh_i = 1'b0;
	logic factory_fill_i = 1'b1;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic reg_wr_i, reg_rd_i, reg_rvalid_o, wr_blocked_o, first_load_done_o, clock_output_disable_o;
	logic [1:0] backup_switch_mode_o;
	logic [3:0] trickle_ctrl_o;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	wire logic [7:0] pm = {1'b0, clock_output_disable_o, backup_switch_mode_o, trickle_ctrl_o};
	cfgm_host host_u (.clk_i, .addr_o(reg_addr_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
		.wdata_o(reg_wdata_i));
	cfgm_top #(.FIRST_REFRESH_CYCLES(N)) dut_u (.clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i,
		.reg_rd_i, .reg_wdata_i, .wp_active_i, .nvm_update_i, .nvm_refresh_i, .factory_fill_i,
		.reg_rdata_o, .reg_rvalid_o, .wr_blocked_o, .first_load_done_o, .clock_output_disable_o,
		.backup_switch_mode_o, .trickle_ctrl_o);
	initial forever #10 clk_i = ~clk_i;
	// whole run is well under 200 cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (error_cnt == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		host_u.xfer(1'b0, a, 8'h00);
		check({7'h00, reg_rvalid_o}, 8'h01);
		check(reg_rdata_o, exp);
	endtask
	// a write during the wait is lost to the power-up load
	task automatic t_power_up();
		host_u.xfer(1'b1, 8'hc0, 8'h5f);
		check(pm, 8'h5f);
		repeat (N - 2) @(negedge clk_i);
		check({7'h00, first_load_done_o}, 8'h00);
		@(negedge clk_i);
		check({7'h00, first_load_done_o}, 8'h01);
		check(pm, 8'h00);
	endtask
	task automatic t_write();
		host_u.xfer(1'b1, 8'hc0, 8'h5f);
		check(pm, 8'h5f);
		rd_chk(8'hc0, 8'h5f);
		host_u.xfer(1'b1, 8'hc0, 8'hff);
		rd_chk(8'hc0, 8'h7f);
		host_u.xfer(1'b1, 8'hca, 8'ha5);
		rd_chk(8'hca, 8'ha5);
		rd_chk(8'hcb, 8'h00);
		// a write below the window must not alias onto the first byte
		host_u.xfer(1'b1, 8'hb0, 8'h11);
		rd_chk(8'hc0, 8'h7f);
	endtask
	task automatic t_protect();
		wp_active_i = 1'b1;
		host_u.xfer(1'b1, 8'hc0, 8'h00);
		check({7'h00, wr_blocked_o}, 8'h01);
		rd_chk(8'hc0, 8'h7f);
		wp_active_i = 1'b0;
	endtask
	// store survives a reset and is reloaded after the refresh delay
	task automatic t_store();
		host_u.xfer(1'b1, 8'hc0, 8'h0f);
		nvm_update_i = 1'b1;
		@(negedge clk_i);
		nvm_update_i = 1'b0;
		host_u.xfer(1'b1, 8'hc0, 8'h3a);
		nvm_refresh_i = 1'b1;
		@(negedge clk_i);
		nvm_refresh_i = 1'b0;
		check(pm, 8'h0f);
		rst_n_i = 1'b0;
		@(negedge clk_i);
		check(pm, 8'h00);
		rst_n_i = 1'b1;
		repeat (N + 1) @(negedge clk_i);
		check(pm, 8'h0f);
		rd_chk(8'hca, 8'ha5);
	endtask
	initial begin
		repeat (3) @(negedge clk_i);
		rst_n_i = 1'b1;
		factory_fill_i = 1'b0;
		t_power_up();
		t_write();
		t_protect();
		t_store();
		wrap_up();
	end
endmodule // testbench
